// [include/apmc_pkg.sv]
// Shared constants and types for the accelerometer power mode controller
package apmc_pkg;

   // Register offsets on the register access port
   localparam logic [5:0] QUIET_LEVEL_OFS = 6'h25;
   localparam logic [5:0] QUIET_DURATION_OFS = 6'h26;
   localparam logic [5:0] RATE_POWER_OFS = 6'h2C;
   localparam logic [5:0] POWER_MODE_OFS = 6'h2D;

   // Field positions in power_mode_control
   localparam int MEASURE_BIT = 3;
   localparam int AUTOSLEEP_BIT = 4;
   localparam int LINK_BIT = 5;

   // Field positions in rate_and_power_select
   localparam int LOW_POWER_BIT = 4;
   localparam int RATE_LSB = 0;
   localparam int RATE_W = 4;

   // Values after reset
   localparam logic [7:0] QUIET_LEVEL_RST = 8'h00;
   localparam logic [7:0] QUIET_DURATION_RST = 8'h00;
   localparam logic [7:0] RATE_POWER_RST = 8'h0A;
   localparam logic [7:0] POWER_MODE_RST = 8'h00;

   // Rate code 1111 is the fastest rate, each lower code halves it
   localparam logic [3:0] RATE_TOP_CODE = 4'hF;
   // Sleep rate is 6.25 Hz, below the 8 Hz ceiling
   localparam logic [3:0] SLEEP_RATE_CODE = 4'h6;

   // Clock and timing figures
   localparam int CLK_PERIOD_NS = 5;
   localparam int CLK_HZ = 1_000_000_000 / CLK_PERIOD_NS;
   localparam int ODR_TOP_HZ = 3200;
   localparam int BASE_PERIOD_CYC = CLK_HZ / ODR_TOP_HZ;
   // Extra turn-on time on top of one output period
   localparam int WAKE_EXTRA_NS = 1_100_000;
   localparam int WAKE_EXTRA_CYC = WAKE_EXTRA_NS / CLK_PERIOD_NS;
   localparam int CNT_W = 32;

   // Power states, Gray coded along standby, warmup, measure, sleep
   typedef enum logic [1:0] {
      ST_STANDBY = 2'b00,
      ST_WARMUP = 2'b01,
      ST_MEASURE = 2'b11,
      ST_SLEEP = 2'b10
   } apmc_state_t;

   // One register access from the serial interface
   typedef struct packed {
      logic wrEn;
      logic rdEn;
      logic [5:0] addr;
      logic [7:0] wrData;
   } apmc_reg_req_t;

   // Power and sampling state shown to the sensing core
   typedef struct packed {
      logic sensorOn;
      logic sampleStrobe;
      logic firstValid;
      logic lowPowerActive;
      logic asleep;
      logic measuring;
   } apmc_status_t;

endpackage

// [logic/apmc_rate_tick.sv]
`timescale 1ns/1ps
// Output data rate divider: one-cycle tick per output period
module apmc_rate_tick #(
   parameter int BASE_PERIOD = apmc_pkg::BASE_PERIOD_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Control
   input wire logic run,
   input wire logic restart,
   input wire logic [3:0] rateCode,
   // Tick out
   output logic tick
);

   logic [apmc_pkg::CNT_W-1:0] cnt_q;
   logic [apmc_pkg::CNT_W-1:0] cnt_d;
   logic [apmc_pkg::CNT_W-1:0] periodLast;
   logic [3:0] shiftAmt;

   // Period doubles for every code below the top; code 0000 still fits 32 bits
   always_comb begin
      shiftAmt = apmc_pkg::RATE_TOP_CODE - rateCode;
      periodLast = (apmc_pkg::CNT_W'(BASE_PERIOD) << shiftAmt) - apmc_pkg::CNT_W'(1);
   end

   // Count up; restart realigns the phase to the caller
   always_comb begin
      tick = 1'b0;
      cnt_d = cnt_q;
      if (restart || !run) begin
         cnt_d = '0;
      end else if (cnt_q >= periodLast) begin
         tick = 1'b1;
         cnt_d = '0;
      end else begin
         cnt_d = cnt_q + apmc_pkg::CNT_W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

endmodule // apmc_rate_tick

// [logic/apmc_power_ctrl.sv]
`timescale 1ns/1ps
// What this block does
// [RL1] Starts in standby with sensing off
// [RL2] Measure bit set enables all sensing
// [RL3] Measure bit cleared returns to standby
// [RL4] Registers read and written in standby
// [RL5] Host configures in standby, then measures
// [RL6] No sampling at all in standby
// [RL7] Standby entry never flushes FIFO contents
// [RL8] Low power bit lowers internal sampling
// [RL9] Host uses low power at 12.5-400 Hz
// [RL10] Four-bit code, 1111 3200 Hz, halving
// [RL11] Host loads quiet threshold and duration
// [RL12] Autosleep plus link bits enable sleeping
// [RL13] Sleep samples below 8 Hz
// [RL14] First output one period plus 1.1 ms
// [RL15] Standby configuration applies at measurement start
module apmc_power_ctrl #(
   parameter int BASE_PERIOD = apmc_pkg::BASE_PERIOD_CYC,
   parameter int WAKE_EXTRA = apmc_pkg::WAKE_EXTRA_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Register access from the serial interface
   input wire apmc_pkg::apmc_reg_req_t regReq,
   output logic [7:0] regRdData,
   output logic regRdValid,
   // Events from motion detection, same clock
   input wire logic quietEvent,
   input wire logic activityEvent,
   // Settings handed to motion detection
   output logic [7:0] quietThreshold,
   output logic [7:0] quietDuration,
   // Sampling control to the sensing core
   output logic [3:0] sampleRateCode,
   output apmc_pkg::apmc_status_t status
);

   // Register file
   logic [7:0] quietLevel_q;
   logic [7:0] quietLevel_d;
   logic [7:0] quietDur_q;
   logic [7:0] quietDur_d;
   logic [7:0] ratePower_q;
   logic [7:0] ratePower_d;
   logic [7:0] powerMode_q;
   logic [7:0] powerMode_d;
   logic [7:0] rdData_q;
   logic [7:0] rdData_d;
   logic rdValid_q;
   logic rdValid_d;

   // Sequencer state
   apmc_pkg::apmc_state_t state_q;
   apmc_pkg::apmc_state_t state_d;
   logic [apmc_pkg::CNT_W-1:0] wait_q;
   logic [apmc_pkg::CNT_W-1:0] wait_d;
   logic extraDone_q;
   logic extraDone_d;
   logic [3:0] runRate_q;
   logic [3:0] runRate_d;
   logic runLowPower_q;
   logic runLowPower_d;
   logic [3:0] effRate_q;
   logic [3:0] effRate_d;
   apmc_pkg::apmc_status_t status_q;
   apmc_pkg::apmc_status_t status_d;

   logic divRun;
   logic divRestart;
   logic divTick;
   logic measureBit;
   logic autoSleepOn;

   // Registers are writable in every state, so standby setup always works
   // [RL4] any register accessible
   always_comb begin
      quietLevel_d = quietLevel_q;
      quietDur_d = quietDur_q;
      ratePower_d = ratePower_q;
      powerMode_d = powerMode_q;
      if (regReq.wrEn) begin
         unique case (regReq.addr)
            apmc_pkg::QUIET_LEVEL_OFS: quietLevel_d = regReq.wrData;
            apmc_pkg::QUIET_DURATION_OFS: quietDur_d = regReq.wrData;
            apmc_pkg::RATE_POWER_OFS: ratePower_d = regReq.wrData;
            apmc_pkg::POWER_MODE_OFS: powerMode_d = regReq.wrData;
            default: ; // Unmapped writes are dropped
         endcase
      end
   end

   // Read data returns one cycle after the strobe; unmapped reads give zero
   always_comb begin
      rdValid_d = regReq.rdEn;
      rdData_d = rdData_q;
      if (regReq.rdEn) begin
         unique case (regReq.addr)
            apmc_pkg::QUIET_LEVEL_OFS: rdData_d = quietLevel_q;
            apmc_pkg::QUIET_DURATION_OFS: rdData_d = quietDur_q;
            apmc_pkg::RATE_POWER_OFS: rdData_d = ratePower_q;
            apmc_pkg::POWER_MODE_OFS: rdData_d = powerMode_q;
            default: rdData_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         quietLevel_q <= apmc_pkg::QUIET_LEVEL_RST;
         quietDur_q <= apmc_pkg::QUIET_DURATION_RST;
         ratePower_q <= apmc_pkg::RATE_POWER_RST;
         powerMode_q <= apmc_pkg::POWER_MODE_RST;
         rdData_q <= 8'h00;
         rdValid_q <= 1'b0;
      end else begin
         quietLevel_q <= quietLevel_d;
         quietDur_q <= quietDur_d;
         ratePower_q <= ratePower_d;
         powerMode_q <= powerMode_d;
         rdData_q <= rdData_d;
         rdValid_q <= rdValid_d;
      end
   end

   // Control bits decoded from the stored power mode register
   // [RL12] autosleep needs both bits
   always_comb begin
      measureBit = powerMode_q[apmc_pkg::MEASURE_BIT];
      autoSleepOn = powerMode_q[apmc_pkg::AUTOSLEEP_BIT] & powerMode_q[apmc_pkg::LINK_BIT];
   end

   // Power sequencer; next state and sampling control
   always_comb begin
      state_d = state_q;
      wait_d = wait_q;
      extraDone_d = extraDone_q;
      runRate_d = runRate_q;
      runLowPower_d = runLowPower_q;
      divRestart = 1'b0;
      status_d = status_q;
      status_d.sampleStrobe = 1'b0;
      status_d.firstValid = 1'b0;
      unique case (state_q)
         apmc_pkg::ST_STANDBY: begin
            if (measureBit) begin
               // [RL2] start measurement
               state_d = apmc_pkg::ST_WARMUP;
               wait_d = apmc_pkg::CNT_W'(WAKE_EXTRA);
               extraDone_d = 1'b0;
               // [RL15] latch standby configuration
               runRate_d = ratePower_q[apmc_pkg::RATE_LSB +: apmc_pkg::RATE_W];
               runLowPower_d = ratePower_q[apmc_pkg::LOW_POWER_BIT];
            end
         end
         apmc_pkg::ST_WARMUP: begin
            if (!measureBit) begin
               state_d = apmc_pkg::ST_STANDBY;
            end else if (!extraDone_q) begin
               // [RL14] settle time before period
               if (wait_q <= apmc_pkg::CNT_W'(1)) begin
                  extraDone_d = 1'b1;
                  divRestart = 1'b1;
               end else begin
                  wait_d = wait_q - apmc_pkg::CNT_W'(1);
               end
            end else if (divTick) begin
               // [RL14] first valid output
               state_d = apmc_pkg::ST_MEASURE;
               status_d.sampleStrobe = 1'b1;
               status_d.firstValid = 1'b1;
            end
         end
         apmc_pkg::ST_MEASURE: begin
            if (!measureBit) begin
               // [RL3] back to standby
               state_d = apmc_pkg::ST_STANDBY;
            end else if (autoSleepOn && quietEvent) begin
               // [RL12] inactivity puts it asleep
               state_d = apmc_pkg::ST_SLEEP;
               divRestart = 1'b1;
            end else begin
               status_d.sampleStrobe = divTick;
            end
         end
         apmc_pkg::ST_SLEEP: begin
            if (!measureBit) begin
               state_d = apmc_pkg::ST_STANDBY;
            end else if (activityEvent || !autoSleepOn) begin
               // Wake-up pays the same settle time as turn-on
               state_d = apmc_pkg::ST_WARMUP;
               wait_d = apmc_pkg::CNT_W'(WAKE_EXTRA);
               extraDone_d = 1'b0;
            end else begin
               status_d.sampleStrobe = divTick;
            end
         end
      endcase
      // [RL13] sleep uses the slow code
      effRate_d = (state_d == apmc_pkg::ST_SLEEP) ? apmc_pkg::SLEEP_RATE_CODE : runRate_d;
      // [RL1] sensing off in standby
      status_d.sensorOn = (state_d != apmc_pkg::ST_STANDBY);
      status_d.measuring = (state_d == apmc_pkg::ST_MEASURE);
      status_d.asleep = (state_d == apmc_pkg::ST_SLEEP);
      // [RL8] reduced internal sampling
      status_d.lowPowerActive = runLowPower_d && (state_d != apmc_pkg::ST_STANDBY);
   end

   // Divider stops in standby so no tick can reach the core
   // [RL6] no sampling in standby
   assign divRun = (state_q != apmc_pkg::ST_STANDBY);

   // [RL10] rate code to period
   apmc_rate_tick #(
      .BASE_PERIOD(BASE_PERIOD)
   ) rateTick (
      .clk(clk),
      .rst_b(rst_b),
      .run(divRun),
      .restart(divRestart),
      .rateCode(effRate_q),
      .tick(divTick)
   );

   // Standby entry only stops sampling; no flush is ever issued, so the FIFO keeps data
   // [RL7] FIFO left intact
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= apmc_pkg::ST_STANDBY;
         wait_q <= '0;
         extraDone_q <= 1'b0;
         runRate_q <= apmc_pkg::RATE_POWER_RST[3:0];
         runLowPower_q <= 1'b0;
         effRate_q <= apmc_pkg::RATE_POWER_RST[3:0];
         status_q <= '0;
      end else begin
         state_q <= state_d;
         wait_q <= wait_d;
         extraDone_q <= extraDone_d;
         runRate_q <= runRate_d;
         runLowPower_q <= runLowPower_d;
         effRate_q <= effRate_d;
         status_q <= status_d;
      end
   end

   // Outputs straight from flops
   assign regRdData = rdData_q;
   assign regRdValid = rdValid_q;
   assign quietThreshold = quietLevel_q;
   assign quietDuration = quietDur_q;
   assign sampleRateCode = effRate_q;
   assign status = status_q;

endmodule // apmc_power_ctrl

// [test/apmc_power_ctrl_assertions.sv]
`timescale 1ns/1ps
// Port-level checks on the power mode controller
module apmc_power_ctrl_assertions #(
   parameter int BASE_PERIOD = apmc_pkg::BASE_PERIOD_CYC,
   parameter int WAKE_EXTRA = apmc_pkg::WAKE_EXTRA_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Register port
   input wire apmc_pkg::apmc_reg_req_t regReq,
   input wire logic regRdValid,
   // Sampling control
   input wire logic [3:0] sampleRateCode,
   input wire apmc_pkg::apmc_status_t status
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic pmWr;
   logic [31:0] gap_q, gap_d;
   // Write to the power mode register
   assign pmWr = regReq.wrEn && regReq.addr == apmc_pkg::POWER_MODE_OFS;
   // Cycles since the last output sample
   always_comb gap_d = status.sampleStrobe ? 32'h0000_0001 : gap_q + 32'h0000_0001;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) gap_q <= '0;
      else gap_q <= gap_d;
   end
   a_rd_answer: assert property (regReq.rdEn |=> regRdValid)
      else $error("read not answered");
   a_rd_single: assert property (!regReq.rdEn |=> !regRdValid)
      else $error("read answer without request");
   a_measure_start: assert property (pmWr && regReq.wrData[apmc_pkg::MEASURE_BIT]
      && !status.sensorOn |-> ##[1:3] status.sensorOn)
      else $error("sensing not switched on");
   a_measure_stop: assert property (pmWr && !regReq.wrData[apmc_pkg::MEASURE_BIT]
      |-> ##[1:3] !status.sensorOn)
      else $error("standby not reached");
   a_standby_quiet: assert property (!status.sensorOn
      |-> !status.sampleStrobe && !status.firstValid)
      else $error("sampling in standby");
   a_standby_flags: assert property (!status.sensorOn
      |-> !status.measuring && !status.asleep && !status.lowPowerActive)
      else $error("mode flag set in standby");
   a_first_strobe: assert property (status.firstValid |-> status.sampleStrobe)
      else $error("first sample without strobe");
   a_rate_period: assert property (status.sampleStrobe && status.measuring
      && !status.firstValid |-> gap_q == (BASE_PERIOD << (15 - int'(sampleRateCode))))
      else $error("output period wrong");
   a_sleep_code: assert property ($past(status.asleep) && status.asleep
      |-> sampleRateCode == apmc_pkg::SLEEP_RATE_CODE)
      else $error("sleep rate wrong");
   c_first: cover property (status.firstValid);
   c_sleep: cover property (status.asleep);
   c_read: cover property (regRdValid);
endmodule // apmc_power_ctrl_assertions

bind apmc_power_ctrl apmc_power_ctrl_assertions #(.BASE_PERIOD(BASE_PERIOD),
   .WAKE_EXTRA(WAKE_EXTRA)) i_chk (.clk(clk), .rst_b(rst_b), .regReq(regReq),
   .regRdValid(regRdValid), .sampleRateCode(sampleRateCode), .status(status));

// [test/apmc_host_model.sv]
`timescale 1ns/1ps
// Host side of the register port, one byte per request
module apmc_host_model (
   // Clock
   input wire logic clk,
   // Register port
   output apmc_pkg::apmc_reg_req_t regReq,
   input wire logic [7:0] regRdData,
   input wire logic regRdValid
);
   initial regReq = '0;
   // Released address and data are inverted so stale values never look valid
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      regReq <= '{1'b1, 1'b0, a, d};
      @(posedge clk);
      regReq <= '{1'b0, 1'b0, ~a, ~d};
   endtask
   // Read waits a bounded few cycles for the answer pulse
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      d = 8'hxx;
      @(posedge clk);
      regReq <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk);
      regReq <= '{1'b0, 1'b0, ~a, 8'hFF};
      repeat (3) begin
         @(negedge clk);
         if (regRdValid === 1'b1) d = regRdData;
      end
   endtask
endmodule // apmc_host_model

// [test/apmc_power_ctrl_bench.sv]
`timescale 1ns/1ps
module apmc_power_ctrl_bench;
   localparam int BP = 4;
   localparam int WX = 10;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic quietEvent = 1'b0;
   logic activityEvent = 1'b0;
   apmc_pkg::apmc_reg_req_t regReq;
   logic [7:0] regRdData, quietThreshold, quietDuration, d;
   logic regRdValid;
   logic [3:0] sampleRateCode;
   apmc_pkg::apmc_status_t status;
   int failCount = 0;
   int checksDone = 0;
   int seed = 32'h0000_6fac;
   always #2.5 clk = ~clk;
   apmc_power_ctrl #(.BASE_PERIOD(BP), .WAKE_EXTRA(WX)) i_apmc_power_ctrl (.clk(clk),
      .rst_b(rst_b), .regReq(regReq), .regRdData(regRdData), .regRdValid(regRdValid),
      .quietEvent(quietEvent), .activityEvent(activityEvent),
      .quietThreshold(quietThreshold), .quietDuration(quietDuration),
      .sampleRateCode(sampleRateCode), .status(status));
   apmc_host_model i_apmc_host_model (.clk(clk), .regReq(regReq), .regRdData(regRdData),
      .regRdValid(regRdValid));
   function automatic int period(input logic [3:0] c);
      return BP << (15 - int'(c));
   endfunction
   task automatic cmpVal(input logic [7:0] got, input logic [7:0] exp, input string what);
      checksDone++;
      if (got !== exp) begin
         failCount++;
         $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic cmpRange(input int got, input int lo, input string what);
      checksDone++;
      if (got < lo || got > lo + 10) begin
         failCount++;
         $display("wrong value at %0t: %s took %0d from %0d", $time, what, got, lo);
      end
   endtask
   task automatic rdChk(input logic [5:0] a, input logic [7:0] exp, input string what);
      i_apmc_host_model.rd(a, d);
      cmpVal(d, exp, what);
   endtask
   // Bounded wait for first sample (sel 0) or sleep (sel 1)
   task automatic waitEv(input logic sel, output int n);
      n = 0;
      while ((sel ? status.asleep : status.firstValid) !== 1'b1) begin
         @(negedge clk);
         n++;
         if (n > 20000) begin
            failCount++;
            $display("wrong value at %0t: wait timed out", $time);
            endSim();
         end
      end
   endtask
   task automatic endSim();
      $display("checks %0d mismatches %0d", checksDone, failCount);
      if (failCount == 0 && checksDone > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      int n;
      logic lp;
      logic [7:0] v;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      rdChk(apmc_pkg::QUIET_LEVEL_OFS, apmc_pkg::QUIET_LEVEL_RST, "thr rst");
      rdChk(apmc_pkg::QUIET_DURATION_OFS, apmc_pkg::QUIET_DURATION_RST, "dur rst");
      rdChk(apmc_pkg::RATE_POWER_OFS, apmc_pkg::RATE_POWER_RST, "rate rst");
      rdChk(apmc_pkg::POWER_MODE_OFS, apmc_pkg::POWER_MODE_RST, "mode rst");
      cmpVal({7'h00, status.sensorOn}, 8'h00, "sensor at start");
      rdChk(6'h00, 8'h00, "unmapped");
      $display("test reset done");
      // Standby configuration with random bytes
      repeat (4) begin
         v = 8'($random(seed));
         i_apmc_host_model.wr(apmc_pkg::QUIET_LEVEL_OFS, v);
         i_apmc_host_model.wr(apmc_pkg::QUIET_DURATION_OFS, ~v);
         rdChk(apmc_pkg::QUIET_LEVEL_OFS, v, "thr");
         cmpVal(quietThreshold, v, "thr out");
         cmpVal(quietDuration, ~v, "dur out");
      end
      $display("test standby config done");
      // Every rate code from 1000 up, low power only where it helps
      for (int c = 8; c <= 15; c++) begin
         lp = (c <= 12) ? 1'($random(seed)) : 1'b0;
         i_apmc_host_model.wr(apmc_pkg::RATE_POWER_OFS, {3'b000, lp, c[3:0]});
         i_apmc_host_model.wr(apmc_pkg::POWER_MODE_OFS, 8'h08);
         waitEv(1'b0, n);
         cmpRange(n, WX + period(c[3:0]), "turn on");
         cmpVal({7'h00, status.measuring}, 8'h01, "measuring");
         cmpVal({4'h0, sampleRateCode}, {4'h0, c[3:0]}, "rate");
         cmpVal({7'h00, status.lowPowerActive}, {7'h00, lp}, "low power");
         i_apmc_host_model.wr(apmc_pkg::RATE_POWER_OFS, 8'h0F ^ c[7:0]);
         @(negedge clk);
         cmpVal({4'h0, sampleRateCode}, {4'h0, c[3:0]}, "rate held");
         i_apmc_host_model.wr(apmc_pkg::POWER_MODE_OFS, 8'h00);
         repeat (3) @(negedge clk);
         cmpVal({7'h00, status.sensorOn}, 8'h00, "standby");
         $display("test rate %0d done", c);
      end
      // Autosleep bit without the link bit must never put it to sleep
      i_apmc_host_model.wr(apmc_pkg::RATE_POWER_OFS, 8'h0F);
      i_apmc_host_model.wr(apmc_pkg::POWER_MODE_OFS, 8'h18);
      waitEv(1'b0, n);
      @(posedge clk) quietEvent <= 1'b1;
      @(posedge clk) quietEvent <= 1'b0;
      repeat (3) @(negedge clk);
      cmpVal({7'h00, status.asleep}, 8'h00, "no link sleep");
      cmpVal({7'h00, status.measuring}, 8'h01, "no link measure");
      i_apmc_host_model.wr(apmc_pkg::POWER_MODE_OFS, 8'h00);
      $display("test no link done");
      // Autosleep entry and wake
      i_apmc_host_model.wr(apmc_pkg::RATE_POWER_OFS, 8'h0A);
      i_apmc_host_model.wr(apmc_pkg::POWER_MODE_OFS, 8'h38);
      waitEv(1'b0, n);
      @(posedge clk) quietEvent <= 1'b1;
      @(posedge clk) quietEvent <= 1'b0;
      // Look only once the state launched at this edge has settled
      @(negedge clk);
      waitEv(1'b1, n);
      cmpRange(n, 0, "sleep entry");
      @(negedge clk);
      cmpVal({4'h0, sampleRateCode}, {4'h0, apmc_pkg::SLEEP_RATE_CODE}, "sleep");
      @(posedge clk) activityEvent <= 1'b1;
      @(posedge clk) activityEvent <= 1'b0;
      waitEv(1'b0, n);
      cmpRange(n, WX + period(4'hA), "wake");
      cmpVal({4'h0, sampleRateCode}, 8'h0A, "wake rate");
      rdChk(apmc_pkg::POWER_MODE_OFS, 8'h38, "mode");
      $display("test autosleep done");
      endSim();
   end
endmodule // apmc_power_ctrl_bench
